// ===== logic/esb_pkg.sv
/*
 * Shared constants and carriers for the error synchronization barrier logic:
 * APB register offsets, field positions, reset values and the packed structs
 * that carry core events in and exception takes out.
 * Assumes a 32-bit APB with byte addresses and one register per aligned word.
 */
package esb_pkg;

    // Bus geometry, syndrome width and level count
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam int          SYN_W         = 25;
    localparam int          LEVELS        = 4;

    // Register offsets
    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_VSYN      = 12'h004;
    localparam logic [11:0] OFF_VDEF      = 12'h008;
    localparam logic [11:0] OFF_STAT      = 12'h00C;

    // Control register fields
    localparam int          CTRL_HYP_PRESENT = 0;
    localparam int          CTRL_HYP_IS_64   = 1;
    localparam int          CTRL_ROUTE       = 2;
    localparam int          CTRL_TRAP        = 3;
    localparam int          CTRL_ROUTE_32    = 4;
    localparam int          CTRL_TRAP_32     = 5;
    localparam int          CTRL_VPEND       = 6;
    localparam int          CTRL_IBE_LO      = 7;
    localparam int          CTRL_IBE_HI      = 9;
    localparam int          CTRL_IN_PLACE    = 10;

    // Deferred syndrome and status fields
    localparam int          VDEF_VALID       = 31;
    localparam int          STAT_FLAG_LO     = 0;
    localparam int          STAT_FLAG_HI     = 3;
    localparam int          STAT_PPEND       = 8;
    localparam int          STAT_VPEND       = 9;

    // Reset values
    localparam logic [31:0] RST_WORD         = 32'h0000_0000;
    localparam logic [24:0] RST_SYN          = 25'h000_0000;
    localparam logic        RST_BIT          = 1'b0;

    typedef enum logic [1:0] {
        USER_LEVEL,
        KERNEL_LEVEL,
        HYPERVISOR_LEVEL,
        MONITOR_LEVEL
    } level_t;

    // Events from the core pipeline, same clock
    typedef struct packed {
        logic        barrier_exec;
        logic        entry;
        logic        ret;
        logic        other_exc_first;
        logic        nonsecure;
        logic        virt_masked;
        logic        phys_masked_cur;
        logic        phys_masked_tgt;
        logic        err_in;
        logic        ext_taken;
        level_t      cur_level;
        level_t      target_level;
    } core_evt_t;

    typedef struct packed {
        logic [31:0] vector_addr;
        logic [31:0] exc_addr;
        logic [31:0] ret_instr_addr;
    } core_addr_t;

    // One exception take decided by this block
    typedef struct packed {
        logic        virt_take;
        logic        phys_take;
        logic        implicit;
        level_t      level;
        logic [31:0] ret_addr;
        logic [24:0] syndrome;
    } take_t;

endpackage : esb_pkg

// ===== logic/sticky_flag.sv
/*
 * One sticky status bit: hardware set, clear from another source.
 * Assumes set and clear are synchronous to clk; set wins a tie.
 */
`timescale 1ns/1ps

module sticky_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic set,
    input  wire logic clr,
    // State
    output logic      q
);

    logic next_q;

    assign next_q = set ? 1'b1 : (clr ? 1'b0 : q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_VAL;
        end else begin
            q <= next_q;
        end
    end

endmodule : sticky_flag

// ===== logic/error_sync_barrier_logic.sv
/*
 * Error synchronization barrier logic of the exception unit: explicit barrier
 * handling of a pending virtual system error, and the implicit barrier at
 * exception entry and return with its syndrome flag. Registers sit on APB:
 * control, virtual syndrome, virtual deferred syndrome and status words.
 * Assumes core events arrive as one-cycle pulses on pclk, already decoded.
 */

// Operation
// - 64-bit hypervisor, route=1, trap=0: explicit barrier also syncs virtual error.
// - 32-bit hypervisor uses its own route=1, trap=0 controls the same way.
// - Unmasked pending virtual error is taken before the barrier completes.
// - Masked pending virtual error clears the virtual pending bit.
// - Masked case copies virtual syndrome to deferred register, sets valid flag.
// - Virtual handling runs alongside, and independent of, physical handling.
// - Per-level enable bit inserts implicit barrier at entry and return.
// - Entry barrier above user level pends all earlier unrecoverable errors.
// - Entry: unmasked pending error taken first, return address is the vector.
// - Entry: masked error stays pending, neither taken nor deferred.
// - Return barrier pends all unrecoverable errors from before the return.
// - Return: unmasked taken with return instruction address; masked stays pending.
// - Implicit barrier syncs all errors, never writes deferred syndrome registers.
// - Error taken at implicit barrier sets that level's implicit flag when take-in-place is off; with it on, the flag clears.
// - Errors after the barrier are not taken there nor flagged.
// - Optionally take error in place of entry, syndrome of faulting instruction.
// - Error taken ahead of return barrier may leave the flag zero.
// - Another exception first leaves the system error pending.
// - Virtual syndrome register holds software value delivered on virtual take; a same-cycle implicit take leaves the syndrome field zero.
`timescale 1ns/1ps

module error_sync_barrier_logic #(
    parameter int SYN_WIDTH = esb_pkg::SYN_W
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,

    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,

    // Core events
    input  wire esb_pkg::core_evt_t evt,
    input  wire esb_pkg::core_addr_t addr,

    // Exception takes and visible state
    output esb_pkg::take_t          take,
    output logic                    phys_pending,
    output logic                    virt_system_error_interrupt_pending
);

    // Control register state
    logic                   hyp_present;
    logic                   hyp_is_64;
    logic                   hyp_route_async_abort;
    logic                   hyp_trap_general;
    logic                   hyp_route_async_abort_32;
    logic                   hyp_trap_general_32;

    // Barrier controls
    logic [3:1]             implicit_barrier_enable;
    logic                   take_in_place;

    // Syndrome storage
    logic [SYN_WIDTH-1:0]   virt_system_error_interrupt_syndrome;
    logic                   deferred_valid_flag;
    logic [SYN_WIDTH-1:0]   deferred_syn;

    // Status flags
    logic [3:0]             implicit_barrier_flag;

    // Bus phases and decode
    logic                   setup;
    logic                   wr_access;
    logic                   hit_ctrl;
    logic                   hit_vsyn;
    logic                   hit_vdef;
    logic                   hit_stat;
    logic                   hit_any;
    logic                   wr_ctrl;
    logic                   wr_vsyn;
    logic                   wr_vdef;
    logic                   wr_stat;

    // Read words
    logic [31:0]            ctrl_word;
    logic [31:0]            vdef_word;
    logic [31:0]            stat_word;
    logic [31:0]            next_rdata;

    assign setup     = psel & ~penable;
    assign wr_access = psel & penable & pready & pwrite;

    // Address decode
    assign hit_ctrl  = (paddr == esb_pkg::OFF_CTRL);
    assign hit_vsyn  = (paddr == esb_pkg::OFF_VSYN);
    assign hit_vdef  = (paddr == esb_pkg::OFF_VDEF);
    assign hit_stat  = (paddr == esb_pkg::OFF_STAT);
    assign hit_any   = hit_ctrl | hit_vsyn | hit_vdef | hit_stat;

    // Write strobes, effective in the access cycle
    assign wr_ctrl   = wr_access & hit_ctrl;
    assign wr_vsyn   = wr_access & hit_vsyn;
    assign wr_vdef   = wr_access & hit_vdef;
    assign wr_stat   = wr_access & hit_stat;

    // Read views
    always_comb begin
        ctrl_word = esb_pkg::RST_WORD;
        ctrl_word[esb_pkg::CTRL_HYP_PRESENT] = hyp_present;
        ctrl_word[esb_pkg::CTRL_HYP_IS_64]   = hyp_is_64;
        ctrl_word[esb_pkg::CTRL_ROUTE]       = hyp_route_async_abort;
        ctrl_word[esb_pkg::CTRL_TRAP]        = hyp_trap_general;
        ctrl_word[esb_pkg::CTRL_ROUTE_32]    = hyp_route_async_abort_32;
        ctrl_word[esb_pkg::CTRL_TRAP_32]     = hyp_trap_general_32;
        ctrl_word[esb_pkg::CTRL_VPEND]       = virt_system_error_interrupt_pending;
        ctrl_word[esb_pkg::CTRL_IBE_HI:esb_pkg::CTRL_IBE_LO] = implicit_barrier_enable;
        ctrl_word[esb_pkg::CTRL_IN_PLACE]    = take_in_place;
    end

    always_comb begin
        vdef_word = esb_pkg::RST_WORD;
        vdef_word[SYN_WIDTH-1:0]         = deferred_syn;
        vdef_word[esb_pkg::VDEF_VALID]   = deferred_valid_flag;
    end

    always_comb begin
        stat_word = esb_pkg::RST_WORD;
        stat_word[esb_pkg::STAT_FLAG_HI:esb_pkg::STAT_FLAG_LO] = implicit_barrier_flag;
        stat_word[esb_pkg::STAT_PPEND]   = phys_pending;
        stat_word[esb_pkg::STAT_VPEND]   = virt_system_error_interrupt_pending;
    end

    assign next_rdata = hit_ctrl ? ctrl_word :
                        hit_vsyn ? {{(32-SYN_WIDTH){1'b0}}, virt_system_error_interrupt_syndrome} :
                        hit_vdef ? vdef_word :
                        hit_stat ? stat_word : esb_pkg::RST_WORD;

    // One wait-free access phase after every setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= esb_pkg::RST_WORD;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            prdata  <= setup ? next_rdata : prdata;
            pslverr <= setup ? ~hit_any : 1'b0;
        end
    end

    // Virtual synchronization on an explicit barrier
    logic                   virt_route;
    logic                   virt_trap;
    logic                   low_level;
    logic                   virt_sync_ok;
    logic                   barrier_virt;
    logic                   virt_take_now;
    logic                   virt_defer_now;
    logic                   virt_clr;

    assign virt_route   = hyp_is_64 ? hyp_route_async_abort : hyp_route_async_abort_32;
    assign virt_trap    = hyp_is_64 ? hyp_trap_general : hyp_trap_general_32;
    assign low_level    = (evt.cur_level == esb_pkg::USER_LEVEL)
                        | (evt.cur_level == esb_pkg::KERNEL_LEVEL);
    assign virt_sync_ok = hyp_present & evt.nonsecure & low_level
                        & virt_route & ~virt_trap;
    // Depends on no physical-error signal, so both paths act in one cycle
    assign barrier_virt   = evt.barrier_exec & virt_sync_ok & virt_system_error_interrupt_pending;
    assign virt_take_now  = barrier_virt & ~evt.virt_masked;
    assign virt_defer_now = barrier_virt & evt.virt_masked;

    // Either outcome consumes the pending bit
    assign virt_clr       = virt_take_now | virt_defer_now;

    // Implicit barrier at entry and return
    logic                   entry_en;
    logic                   ret_en;
    logic                   pend_now;
    logic                   entry_take;
    logic                   ret_take;
    logic                   impl_take;
    logic                   impl_flag;
    esb_pkg::level_t        impl_level;
    logic [31:0]            impl_addr;
    logic [3:0]             ibe_by_level;
    logic                   phys_set;
    logic                   phys_clr;
    logic [3:0]             flag_set;
    logic [3:0]             flag_clr;

    // User level has no enable bit; its slot reads as zero
    assign ibe_by_level = {implicit_barrier_enable, 1'b0};
    assign entry_en   = evt.entry & (evt.target_level != esb_pkg::USER_LEVEL)
                      & ibe_by_level[evt.target_level];
    assign ret_en     = evt.ret & (evt.cur_level != esb_pkg::USER_LEVEL)
                      & ibe_by_level[evt.cur_level];

    // Errors arriving in the barrier cycle count as earlier ones
    assign pend_now   = phys_pending | evt.err_in;
    assign entry_take = entry_en & pend_now & ~evt.phys_masked_tgt
                      & ~evt.other_exc_first;
    assign ret_take   = ~entry_en & ret_en & pend_now & ~evt.phys_masked_cur
                      & ~evt.other_exc_first;
    assign impl_take  = entry_take | ret_take;
    assign impl_level = entry_take ? evt.target_level : evt.cur_level;
    assign impl_flag  = ~take_in_place;
    assign impl_addr  = ret_take      ? addr.ret_instr_addr :
                        take_in_place ? addr.exc_addr : addr.vector_addr;

    // Physical pending: new errors after a barrier wait for the normal path
    assign phys_set = evt.err_in & ~impl_take;
    assign phys_clr = impl_take | evt.ext_taken;

    sticky_flag #(
        .RESET_VAL (esb_pkg::RST_BIT)
    ) u_phys_pending (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (phys_set),
        .clr   (phys_clr),
        .q     (phys_pending)
    );

    // Per-level implicit flag of the exception syndrome
    for (genvar lv = 0; lv < esb_pkg::LEVELS; lv++) begin : g_flag
        assign flag_set[lv] = impl_take & impl_flag & (impl_level == lv);
        // Written one clears; an implicit take without the flag clears too
        assign flag_clr[lv] = (impl_take & ~impl_flag & (impl_level == lv))
                            | (wr_stat & pwdata[esb_pkg::STAT_FLAG_LO + lv]);

        sticky_flag #(
            .RESET_VAL (esb_pkg::RST_BIT)
        ) u_flag (
            .clk   (pclk),
            .rst_n (presetn),
            .set   (flag_set[lv]),
            .clr   (flag_clr[lv]),
            .q     (implicit_barrier_flag[lv])
        );
    end

    // Take outputs
    esb_pkg::take_t         next_take;

    // Implicit take wins the shared fields
    always_comb begin
        next_take           = '0;
        next_take.virt_take = virt_take_now;
        next_take.phys_take = impl_take;
        if (impl_take) begin
            next_take.implicit = impl_flag;
            next_take.level    = impl_level;
            next_take.ret_addr = impl_addr;
        end else if (virt_take_now) begin
            next_take.level    = esb_pkg::KERNEL_LEVEL;
            next_take.ret_addr = addr.ret_instr_addr;
            next_take.syndrome = virt_system_error_interrupt_syndrome;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take <= '0;
        end else begin
            take <= next_take;
        end
    end

    // Hypervisor routing controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hyp_present              <= esb_pkg::RST_BIT;
            hyp_is_64                <= esb_pkg::RST_BIT;
            hyp_route_async_abort    <= esb_pkg::RST_BIT;
            hyp_trap_general         <= esb_pkg::RST_BIT;
            hyp_route_async_abort_32 <= esb_pkg::RST_BIT;
            hyp_trap_general_32      <= esb_pkg::RST_BIT;
        end else if (wr_ctrl) begin
            hyp_present              <= pwdata[esb_pkg::CTRL_HYP_PRESENT];
            hyp_is_64                <= pwdata[esb_pkg::CTRL_HYP_IS_64];
            hyp_route_async_abort    <= pwdata[esb_pkg::CTRL_ROUTE];
            hyp_trap_general         <= pwdata[esb_pkg::CTRL_TRAP];
            hyp_route_async_abort_32 <= pwdata[esb_pkg::CTRL_ROUTE_32];
            hyp_trap_general_32      <= pwdata[esb_pkg::CTRL_TRAP_32];
        end
    end

    // Implicit barrier controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            implicit_barrier_enable  <= '0;
            take_in_place            <= esb_pkg::RST_BIT;
        end else if (wr_ctrl) begin
            implicit_barrier_enable  <= pwdata[esb_pkg::CTRL_IBE_HI:esb_pkg::CTRL_IBE_LO];
            take_in_place            <= pwdata[esb_pkg::CTRL_IN_PLACE];
        end
    end

    // Virtual pending: a control write beats the hardware clear
    logic                   next_vpend;

    assign next_vpend = wr_ctrl ? pwdata[esb_pkg::CTRL_VPEND] :
                        virt_clr ? 1'b0 :
                        virt_system_error_interrupt_pending;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            virt_system_error_interrupt_pending <= esb_pkg::RST_BIT;
        end else begin
            virt_system_error_interrupt_pending <= next_vpend;
        end
    end

    // Software syndrome for the next virtual take
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            virt_system_error_interrupt_syndrome <= esb_pkg::RST_SYN[SYN_WIDTH-1:0];
        end else if (wr_vsyn) begin
            virt_system_error_interrupt_syndrome <= pwdata[SYN_WIDTH-1:0];
        end
    end

    // Deferred syndrome: the explicit virtual path or an APB write loads it; the virtual path wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deferred_valid_flag <= esb_pkg::RST_BIT;
            deferred_syn        <= esb_pkg::RST_SYN[SYN_WIDTH-1:0];
        end else if (virt_defer_now) begin
            deferred_valid_flag <= 1'b1;
            deferred_syn        <= virt_system_error_interrupt_syndrome;
        end else if (wr_vdef) begin
            deferred_valid_flag <= pwdata[esb_pkg::VDEF_VALID];
            deferred_syn        <= pwdata[SYN_WIDTH-1:0];
        end
    end

endmodule : error_sync_barrier_logic

// ===== sim/error_sync_barrier_logic_chk.sv
/*
 * Port-level checks of the barrier logic, with a shadow of the control word.
 * Assumes control writes land only at a completed APB write access.
 */
`timescale 1ns/1ps

module error_sync_barrier_logic_chk (
    // Clock and reset
    input wire logic                pclk,
    input wire logic                presetn,
    // APB slave side
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pready,
    // Core side
    input wire esb_pkg::core_evt_t  evt,
    input wire esb_pkg::core_addr_t addr,
    input wire esb_pkg::take_t      take,
    input wire logic                phys_pending,
    input wire logic                virt_system_error_interrupt_pending
);
    logic [10:0] ctrl;
    logic [3:0]  ibe;
    logic        ctrl_wr, route_ok, virt_ok, ibe_tgt, ibe_cur, err_any;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign ctrl_wr  = psel && penable && pready && pwrite && (paddr == esb_pkg::OFF_CTRL);
    assign route_ok = ctrl[1] ? (ctrl[2] && !ctrl[3]) : (ctrl[4] && !ctrl[5]);
    assign virt_ok  = ctrl[0] && route_ok && evt.nonsecure
                      && (evt.cur_level <= esb_pkg::KERNEL_LEVEL);
    assign ibe      = {ctrl[9:7], 1'b0};
    assign ibe_tgt  = evt.entry && ibe[evt.target_level];
    assign ibe_cur  = evt.ret && !evt.entry && ibe[evt.cur_level];
    assign err_any  = evt.err_in || phys_pending;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
        end else if (ctrl_wr) begin
            ctrl <= pwdata[10:0];
        end
    end

    a_virt_take_now: assert property (
        evt.barrier_exec && virt_ok && !evt.virt_masked && virt_system_error_interrupt_pending
        |=> take.virt_take && !virt_system_error_interrupt_pending && take.level == esb_pkg::KERNEL_LEVEL
    ) else $error("Unmasked virtual error not taken at barrier");
    a_virt_defer_clr: assert property (
        evt.barrier_exec && virt_ok && evt.virt_masked && virt_system_error_interrupt_pending
        |=> !virt_system_error_interrupt_pending && !take.virt_take
    ) else $error("Masked virtual error not deferred at barrier");
    a_virt_untouched: assert property (
        evt.barrier_exec && !virt_ok && !ctrl_wr
        |=> $stable(virt_system_error_interrupt_pending) && !take.virt_take
    ) else $error("Virtual state changed without sync conditions");
    a_entry_take: assert property (
        ibe_tgt && err_any && !evt.phys_masked_tgt && !evt.other_exc_first
        && !evt.ext_taken && !ctrl[10]
        |=> take.phys_take && take.implicit && take.level == $past(evt.target_level)
            && take.ret_addr == $past(addr.vector_addr)
    ) else $error("Entry barrier take wrong");
    a_entry_masked: assert property (
        ibe_tgt && err_any && evt.phys_masked_tgt && !evt.ext_taken
        |=> phys_pending && !take.phys_take
    ) else $error("Masked error not left pending at entry");
    a_return_take: assert property (
        ibe_cur && err_any && !evt.phys_masked_cur && !evt.other_exc_first && !evt.ext_taken
        |=> take.phys_take && take.level == $past(evt.cur_level)
            && take.ret_addr == $past(addr.ret_instr_addr)
    ) else $error("Return barrier take wrong");
    a_other_first: assert property (
        evt.other_exc_first && err_any && !evt.ext_taken |=> phys_pending && !take.phys_take
    ) else $error("Error not pending behind other exception");
    a_take_cause: assert property (
        take.phys_take |-> $past(ibe_tgt || ibe_cur)
    ) else $error("Physical take without an enabled barrier");
endmodule : error_sync_barrier_logic_chk

bind error_sync_barrier_logic error_sync_barrier_logic_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .evt(evt), .addr(addr),
    .take(take), .phys_pending(phys_pending), .virt_system_error_interrupt_pending(virt_system_error_interrupt_pending)
);

// ===== sim/tb_error_sync_barrier_logic.sv
/*
 * Self-checking bench: APB register tasks and one-cycle core event pulses.
 * Assumes one-cycle APB answers and take pulses one cycle after each event.
 */
`timescale 1ns/1ps

module tb_error_sync_barrier_logic;
    localparam esb_pkg::level_t USR = esb_pkg::USER_LEVEL;
    localparam esb_pkg::level_t KRN = esb_pkg::KERNEL_LEVEL;
    localparam esb_pkg::level_t HYP = esb_pkg::HYPERVISOR_LEVEL;

    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    esb_pkg::core_evt_t  evt, e;
    esb_pkg::core_addr_t addr;
    esb_pkg::take_t      take, seen;
    logic                phys_pending, virt_system_error_interrupt_pending;
    logic [7:0]          cv [7];
    int                  fail_count, n_tests;

    error_sync_barrier_logic uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .evt(evt), .addr(addr), .take(take), .phys_pending(phys_pending),
        .virt_system_error_interrupt_pending(virt_system_error_interrupt_pending)
    );

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            fail_count++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One event cycle, then look at the take pulse
    task automatic fire(input esb_pkg::core_evt_t ev);
        @(posedge pclk);
        evt <= ev;
        @(posedge pclk);
        evt <= '0;
        #1;
        seen = take;
    endtask : fire

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        evt = '0;
        addr = '{32'h0000_1000, 32'h0000_2000, 32'h0000_3000};
        cv = '{8'h51, 8'h4F, 8'h71, 8'h46, 8'h43, 8'h47, 8'h47};
        fail_count = 0;
        n_tests = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 12'(4 * k), '0);
            check(rd, 64'h0);
        end
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        check({err, rd}, {1'b1, 32'h0});
        $display("Reset and map test done");

        apb(1'b1, esb_pkg::OFF_VSYN, 32'hFFAA_5533);
        apb(1'b0, esb_pkg::OFF_VSYN, '0);
        check(rd, 64'h01AA_5533);
        apb(1'b1, esb_pkg::OFF_CTRL, 32'h0000_0047);
        e = '0;
        e.barrier_exec = 1'b1;
        e.nonsecure = 1'b1;
        e.virt_masked = 1'b1;
        e.cur_level = KRN;
        fire(e);
        check({seen, virt_system_error_interrupt_pending}, 64'h0);
        apb(1'b0, esb_pkg::OFF_VDEF, '0);
        check(rd, 64'h81AA_5533);
        apb(1'b1, esb_pkg::OFF_CTRL, 32'h0000_0047);
        e.virt_masked = 1'b0;
        fire(e);
        check({seen.virt_take, seen.level, seen.syndrome}, {1'b1, KRN, 25'h1AA5533});
        check(virt_system_error_interrupt_pending, 1'b0);
        apb(1'b1, esb_pkg::OFF_VDEF, '0);
        for (int k = 0; k < 7; k++) begin
            apb(1'b1, esb_pkg::OFF_CTRL, {24'h0, cv[k]});
            e.nonsecure = (k != 5);
            e.virt_masked = (k != 0);
            e.cur_level = (k == 6) ? HYP : USR;
            fire(e);
            check({seen.virt_take, virt_system_error_interrupt_pending}, (k == 0) ? 2'b10 : 2'b01);
        end
        apb(1'b0, esb_pkg::OFF_VDEF, '0);
        check(rd, 64'h0);
        $display("Virtual barrier test done");

        apb(1'b1, esb_pkg::OFF_CTRL, 32'h0000_0100);
        e = '0;
        e.entry = 1'b1;
        e.target_level = HYP;
        e.cur_level = HYP;
        e.err_in = 1'b1;
        fire(e);
        check({seen.phys_take, seen.implicit, seen.level, seen.ret_addr}, {2'b11, HYP, 32'h1000});
        check(phys_pending, 1'b0);
        apb(1'b0, esb_pkg::OFF_STAT, '0);
        check(rd, 64'h4);
        e.phys_masked_tgt = 1'b1;
        fire(e);
        check({seen.phys_take, phys_pending}, 2'b01);
        apb(1'b0, esb_pkg::OFF_VDEF, '0);
        check(rd, 64'h0);
        e = '0;
        e.ret = 1'b1;
        e.cur_level = HYP;
        fire(e);
        check({seen.phys_take, seen.ret_addr, phys_pending}, {1'b1, 32'h3000, 1'b0});
        e.err_in = 1'b1;
        e.phys_masked_cur = 1'b1;
        fire(e);
        check({seen.phys_take, phys_pending}, 2'b01);
        e = '0;
        e.entry = 1'b1;
        e.other_exc_first = 1'b1;
        e.target_level = HYP;
        fire(e);
        check({seen.phys_take, phys_pending}, 2'b01);
        e.other_exc_first = 1'b0;
        e.target_level = KRN;
        fire(e);
        check({seen.phys_take, phys_pending}, 2'b01);
        apb(1'b1, esb_pkg::OFF_CTRL, 32'h0000_0500);
        e.target_level = HYP;
        fire(e);
        check({seen.phys_take, seen.implicit, seen.ret_addr}, {2'b10, 32'h2000});
        e.entry = 1'b0;
        e.ret = 1'b1;
        e.cur_level = HYP;
        e.err_in = 1'b1;
        fire(e);
        check({seen.phys_take, seen.ret_addr, phys_pending}, {1'b1, 32'h3000, 1'b0});
        check(seen.implicit, 1'b0);
        e.ret = 1'b0;
        fire(e);
        check({seen.phys_take, phys_pending}, 2'b01);
        $display("Implicit barrier test done");
        tally_and_finish();
    end
endmodule : tb_error_sync_barrier_logic
